/* logic/rpc_pkg.sv */
// constants, register map and carrier types of the resonant protection block
//
// Notes on behaviour
// RULE1: overvoltage trips only after five consecutive switching cycles above threshold.
// RULE2: one converter alternates between output-sense and boost-sense readings.
// RULE3: overvoltage trip latches protection and pulls the boost-sense pin low.
// RULE4: conducting switch turns off early when primary current approaches zero.
// RULE5: near-zero current thresholds are -100 mV and +100 mV per phase.
// RULE6: capacitive-mode avoidance is no fault; switching simply continues shortened.
// RULE7: overcurrent cuts the active gate for that phase only.
// RULE8: five consecutive overcurrent cycles latch protection and disable the boost stage.
// RULE9: overtemperature latches protection and disables the boost stage.
// RULE10: overpower counter runs above threshold; limit 50 or 200 ms trips protection.
// RULE11: capacitor-sense swing is clamped at the 150 or 200 percent level.
// RULE12: one setting disables the overpower counter altogether.
// RULE13: configuration resistors are read and latched before switching starts.
// RULE14: burst resistor 22k, 15k, 10k, 6.8k selects 200 to 1600 Hz.
// RULE15: settings resistor below 10 kilohm means shorted pin; start-up inhibited.
// RULE16: 46.4 kilohm code allows endless 200 percent operation.
// RULE17: other eight codes combine power level, timer length and restart or latch.
// RULE18: end-of-power-good time is 190 ms with 200 ms timer, 45 ms with 50.
// RULE19: during overpower protection the high-voltage start-up path stays enabled.
// RULE20: latched protection leaves only through full power-removal reset.
// RULE21: protection entry stops switching at once and drives the settings pin low.
// RULE22: measured resistances map to nearest code and hold until next power-up.
// RULE23: restart mode waits one second, then restarts including settings re-read.
package rpc_pkg;
   localparam int CLK_KHZ = 125000;
   localparam int OPP_SHORT_MS = 50;
   localparam int OPP_LONG_MS = 200;
   localparam int PG_SHORT_MS = 45;
   localparam int PG_LONG_MS = 190;
   localparam int RESTART_MS = 1000;
   localparam logic [2:0] QUAL_CYCLES = 3'h5;
   // current thresholds in mV, applied by the analog comparators on the pin
   localparam int CAPM_LS_MV = -100;
   localparam int CAPM_HS_MV = 100;
   // resistances are measured in units of 0.1 kilohm
   localparam logic [11:0] SET_SHORT = 12'h064;
   localparam logic [11:0] SET_CODES [9] = '{12'h1D0, 12'h218, 12'h26B, 12'h2CB,
      12'h339, 12'h3B9, 12'h44C, 12'h4F6, 12'h5BE};
   localparam logic [11:0] BURST_CODES [4] = '{12'h0DC, 12'h096, 12'h064, 12'h044};
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OVP = 8'h04;
   localparam logic [7:0] ADDR_OPP = 8'h08;
   localparam logic [7:0] ADDR_CLAMP = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_SETTINGS = 8'h14;
   localparam logic [7:0] ADDR_BOOST = 8'h18;
   localparam int CLAMP_HI_POS = 16;
   localparam logic [9:0] OVP_RESET = 10'h3FF;
   localparam logic [9:0] OPP_RESET = 10'h3FF;
   localparam logic [9:0] CLAMP_RESET = 10'h3FF;
   typedef struct packed {
      logic capmLs;
      logic capmHs;
      logic ocp;
      logic otp;
   } rpc_sense_t;
   typedef struct packed {
      logic shorted;
      logic infinite;
      logic pow150;
      logic longTimer;
      logic latchMode;
      logic [1:0] burstSel;
      logic [11:0] gateLsRes;
   } rpc_cfg_t;
   typedef struct packed {
      logic ovp;
      logic ocp;
      logic otp;
      logic opp;
   } rpc_trip_t;
endpackage

/* logic/rpc_protection.sv */
// protection, settings decode and register slave of the resonant stage controller
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module rpc_protection #(
   parameter int OPP_SHORT_CYC = rpc_pkg::OPP_SHORT_MS * rpc_pkg::CLK_KHZ,
   parameter int OPP_LONG_CYC = rpc_pkg::OPP_LONG_MS * rpc_pkg::CLK_KHZ,
   parameter int PG_SHORT_CYC = rpc_pkg::PG_SHORT_MS * rpc_pkg::CLK_KHZ,
   parameter int PG_LONG_CYC = rpc_pkg::PG_LONG_MS * rpc_pkg::CLK_KHZ,
   parameter int RESTART_CYC = rpc_pkg::RESTART_MS * rpc_pkg::CLK_KHZ
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rpc_pkg::rpc_sense_t senseRaw,
   input wire logic adcDone,
   input wire logic [9:0] adcData,
   output logic adcSelBoost,
   input wire logic cfgValid,
   input wire logic [11:0] cfgSetRes,
   input wire logic [11:0] cfgBurstRes,
   input wire logic [11:0] cfgGateLsRes,
   input wire logic cycleStart,
   input wire logic gateLsReq,
   input wire logic gateHsReq,
   input wire logic [9:0] capSwing,
   output logic [9:0] capSwingLimited,
   output logic lowSideGate,
   output logic highSideGate,
   output logic boostPinOut,
   output logic boostPinOe,
   output logic settingsPinOut,
   output logic settingsPinOe,
   output logic hvStartupEn,
   output logic [1:0] burstSel
);

   // ************************************************************
   // state and storage
   // ************************************************************
   typedef enum logic [2:0] {
      ST_INIT, ST_INHIBIT, ST_READY, ST_RUN, ST_RESTART, ST_LATCHED
   } rpc_state_t;

   rpc_state_t state_q, state_d;
   rpc_pkg::rpc_sense_t sync1_q, sync2_q, sync3_q, sense_q;
   rpc_pkg::rpc_cfg_t cfg_q, cfgNew;
   rpc_pkg::rpc_trip_t trip_q, tripNow;
   logic startEn_q;
   logic [9:0] ovpLevel_q, oppLevel_q, clamp150_q, clamp200_q, boostSample_q;
   logic ovpAbove_q;
   logic [2:0] ovpCnt_q, ocpCnt_q;
   logic ocpSeen_q;
   logic cutLs_q, cutHs_q;
   logic [27:0] oppCnt_q, restartCnt_q;
   logic lsGate_q, hsGate_q;
   logic [9:0] swingLim_q;
   logic [31:0] rdData_q;
   logic rdErr_q, rdValid_q;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // a change is taken only once the second and third stage agree
   genvar gi;
   generate
      for (gi = 0; gi < $bits(rpc_pkg::rpc_sense_t); gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (rst) begin
               sense_q[gi] <= 1'b0;
            end else if (clkEn && (sync2_q[gi] == sync3_q[gi])) begin
               sense_q[gi] <= sync3_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else if (clkEn) begin
         sync1_q <= senseRaw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // ************************************************************
   // settings decode
   // ************************************************************
   function automatic logic [11:0] absDiff(input logic [11:0] a, input logic [11:0] b);
      absDiff = (a > b) ? (a - b) : (b - a);
   endfunction

   function automatic logic [3:0] nearestSet(input logic [11:0] r);
      logic [3:0] best;
      logic [11:0] bestDist;
      best = 4'h0;
      bestDist = absDiff(r, rpc_pkg::SET_CODES[0]);
      for (int i = 1; i < 9; i++) begin
         if (absDiff(r, rpc_pkg::SET_CODES[i]) < bestDist) begin
            best = 4'(i);
            bestDist = absDiff(r, rpc_pkg::SET_CODES[i]);
         end
      end
      nearestSet = best;
   endfunction

   function automatic logic [1:0] nearestBurst(input logic [11:0] r);
      logic [1:0] best;
      logic [11:0] bestDist;
      best = 2'h0;
      bestDist = absDiff(r, rpc_pkg::BURST_CODES[0]);
      for (int i = 1; i < 4; i++) begin
         if (absDiff(r, rpc_pkg::BURST_CODES[i]) < bestDist) begin
            best = 2'(i);
            bestDist = absDiff(r, rpc_pkg::BURST_CODES[i]);
         end
      end
      nearestBurst = best;
   endfunction

   wire logic [3:0] setIdx = nearestSet(cfgSetRes); // [RULE22]
   wire logic [2:0] comboBits = 3'(setIdx - 4'h1);

   // codes 1..8: bit0 picks the short timer, bit1 the 150 level, bit2 latching
   always_comb begin
      cfgNew.shorted = cfgSetRes < rpc_pkg::SET_SHORT; // [RULE15]
      cfgNew.infinite = setIdx == 4'h0; // [RULE16]
      cfgNew.pow150 = !cfgNew.infinite && comboBits[1]; // [RULE17]
      cfgNew.longTimer = cfgNew.infinite || !comboBits[0]; // [RULE17]
      cfgNew.latchMode = !cfgNew.infinite && comboBits[2]; // [RULE17]
      cfgNew.burstSel = nearestBurst(cfgBurstRes); // [RULE14]
      cfgNew.gateLsRes = cfgGateLsRes;
   end

   wire logic cfgTake = (state_q == ST_INIT) && cfgValid;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_q <= '0;
      end else if (clkEn && cfgTake) begin
         cfg_q <= cfgNew; // [RULE13] [RULE22]
      end
   end

   // ************************************************************
   // shared converter and overvoltage qualifier
   // ************************************************************
   // the output-sense reading refreshes only every other conversion,
   // so the trip may come some cycles after the fifth
   wire logic running = state_q == ST_RUN;
   wire logic outSample = adcDone && !adcSelBoost;
   wire logic boostSample = adcDone && adcSelBoost;

   always_ff @(posedge mclk) begin
      if (rst) begin
         adcSelBoost <= 1'b0;
         ovpAbove_q <= 1'b0;
         boostSample_q <= '0;
      end else if (clkEn) begin
         if (adcDone) begin
            adcSelBoost <= !adcSelBoost; // [RULE2]
         end
         if (outSample) begin
            ovpAbove_q <= adcData > ovpLevel_q; // [RULE2]
         end
         if (boostSample) begin
            boostSample_q <= adcData;
         end
      end
   end

   wire logic [2:0] ovpCntInc = ovpCnt_q + 3'h1;
   wire logic ovpTrip = running && cycleStart && ovpAbove_q &&
      (ovpCntInc == rpc_pkg::QUAL_CYCLES); // [RULE1]

   always_ff @(posedge mclk) begin
      if (rst) begin
         ovpCnt_q <= '0;
      end else if (clkEn && cycleStart) begin
         ovpCnt_q <= (running && ovpAbove_q) ? ovpCntInc : 3'h0; // [RULE1]
      end
   end

   // ************************************************************
   // gate cut-off: capacitive-mode avoidance and overcurrent
   // ************************************************************
   // the capacitive-mode cut is no fault; an overcurrent cut ends the phase early but counts toward the five-cycle trip
   wire logic cutLsNow = sense_q.capmLs || sense_q.ocp; // [RULE4] [RULE5] [RULE7]
   wire logic cutHsNow = sense_q.capmHs || sense_q.ocp; // [RULE4] [RULE5] [RULE7]
   wire logic lsOn = gateLsReq && !cutLs_q && !cutLsNow;
   wire logic hsOn = gateHsReq && !cutHs_q && !cutHsNow;
   wire logic ocpInPhase = sense_q.ocp && (gateLsReq || gateHsReq);

   always_ff @(posedge mclk) begin
      if (rst) begin
         cutLs_q <= 1'b0;
         cutHs_q <= 1'b0;
         ocpSeen_q <= 1'b0;
         ocpCnt_q <= '0;
      end else if (clkEn) begin
         cutLs_q <= gateLsReq && (cutLs_q || cutLsNow); // [RULE6]
         cutHs_q <= gateHsReq && (cutHs_q || cutHsNow); // [RULE6]
         if (cycleStart) begin
            ocpSeen_q <= ocpInPhase;
            ocpCnt_q <= (running && ocpSeen_q) ? ocpCnt_q + 3'h1 : 3'h0; // [RULE8]
         end else if (ocpInPhase) begin
            ocpSeen_q <= 1'b1;
         end
      end
   end

   wire logic ocpTrip = running && cycleStart && ocpSeen_q &&
      (ocpCnt_q + 3'h1 == rpc_pkg::QUAL_CYCLES); // [RULE8]

   // ************************************************************
   // overpower timer and swing clamp
   // ************************************************************
   wire logic [9:0] clampMax = cfg_q.pow150 ? clamp150_q : clamp200_q;
   wire logic oppAbove = running && !cfg_q.infinite && (capSwing > oppLevel_q); // [RULE12]
   wire logic [27:0] oppLimit = cfg_q.longTimer ? 28'(OPP_LONG_CYC) : 28'(OPP_SHORT_CYC);
   wire logic [27:0] pgLimit = cfg_q.longTimer ? 28'(PG_LONG_CYC) : 28'(PG_SHORT_CYC);
   wire logic oppTrip = oppAbove && (oppCnt_q >= oppLimit); // [RULE10]
   wire logic pgWarn = running && !cfg_q.infinite && (oppCnt_q >= pgLimit); // [RULE18]

   always_ff @(posedge mclk) begin
      if (rst) begin
         oppCnt_q <= '0;
         swingLim_q <= '0;
      end else if (clkEn) begin
         oppCnt_q <= oppAbove ? oppCnt_q + 28'h1 : 28'h0; // [RULE10]
         swingLim_q <= (capSwing > clampMax) ? clampMax : capSwing; // [RULE11]
      end
   end

   // ************************************************************
   // protection state machine
   // ************************************************************
   always_comb begin
      tripNow.ovp = ovpTrip;
      tripNow.ocp = ocpTrip;
      tripNow.otp = sense_q.otp && (state_q != ST_INIT) && (state_q != ST_INHIBIT); // [RULE9]
      tripNow.opp = oppTrip;
   end

   wire logic restartDone = restartCnt_q >= 28'(RESTART_CYC - 1);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_INIT: begin
            if (cfgValid) begin
               state_d = cfgNew.shorted ? ST_INHIBIT : ST_READY; // [RULE15]
            end
         end
         ST_INHIBIT: begin
            state_d = ST_INHIBIT;
         end
         ST_READY: begin
            if (tripNow.otp) begin
               state_d = ST_LATCHED;
            end else if (startEn_q) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (tripNow.ovp || tripNow.ocp || tripNow.otp) begin
               state_d = ST_LATCHED; // [RULE3] [RULE8] [RULE9]
            end else if (tripNow.opp) begin
               state_d = cfg_q.latchMode ? ST_LATCHED : ST_RESTART; // [RULE10]
            end
         end
         ST_RESTART: begin
            if (tripNow.otp) begin
               state_d = ST_LATCHED;
            end else if (restartDone) begin
               state_d = ST_INIT; // [RULE23]
            end
         end
         ST_LATCHED: begin
            state_d = ST_LATCHED; // [RULE20]
         end
         default: begin
            state_d = ST_LATCHED;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= ST_INIT;
         trip_q <= '0;
         restartCnt_q <= '0;
      end else if (clkEn) begin
         state_q <= state_d;
         trip_q <= trip_q | tripNow; // [RULE20]
         restartCnt_q <= (state_q == ST_RESTART) ? restartCnt_q + 28'h1 : 28'h0; // [RULE23]
      end
   end

   // ************************************************************
   // pin drivers
   // ************************************************************
   // gates drop in the same edge that moves the state out of running
   wire logic keepSwitching = running && (state_d == ST_RUN); // [RULE21]
   wire logic protectState = (state_q == ST_LATCHED) || (state_q == ST_RESTART);

   always_ff @(posedge mclk) begin
      if (rst) begin
         lsGate_q <= 1'b0;
         hsGate_q <= 1'b0;
      end else if (clkEn) begin
         lsGate_q <= keepSwitching && lsOn; // [RULE7] [RULE21]
         hsGate_q <= keepSwitching && hsOn; // [RULE7] [RULE21]
      end
   end

   assign lowSideGate = lsGate_q;
   assign highSideGate = hsGate_q;
   assign capSwingLimited = swingLim_q;
   assign burstSel = cfg_q.burstSel;
   // open-drain pull-down: released only while ready or running
   assign boostPinOut = 1'b0;
   assign boostPinOe = !((state_q == ST_READY) || (state_q == ST_RUN)); // [RULE3] [RULE8] [RULE9]
   // the settings pin is measured during init, so it is not driven then
   assign settingsPinOe = state_q != ST_INIT;
   assign settingsPinOut = (state_q == ST_READY) || pgWarn; // [RULE21] [RULE18]
   assign hvStartupEn = !running || protectState; // [RULE19]

   // ************************************************************
   // register slave
   // ************************************************************
   wire logic setupPhase = psel && !penable;
   wire logic wrDo = psel && penable && pwrite && pready;
   wire logic hitCtrl = paddr == rpc_pkg::ADDR_CTRL;
   wire logic hitOvp = paddr == rpc_pkg::ADDR_OVP;
   wire logic hitOpp = paddr == rpc_pkg::ADDR_OPP;
   wire logic hitClamp = paddr == rpc_pkg::ADDR_CLAMP;
   wire logic hitStatus = paddr == rpc_pkg::ADDR_STATUS;
   wire logic hitSettings = paddr == rpc_pkg::ADDR_SETTINGS;
   wire logic hitBoost = paddr == rpc_pkg::ADDR_BOOST;
   wire logic hitAny = hitCtrl || hitOvp || hitOpp || hitClamp || hitStatus ||
      hitSettings || hitBoost;
   wire logic [31:0] statusWord = {17'h0, pgWarn, ocpCnt_q, ovpCnt_q, trip_q,
      1'b0, state_q};
   wire logic [31:0] settingsWord = {12'h0, cfg_q.gateLsRes, 1'b0, cfg_q.burstSel,
      cfg_q.latchMode, cfg_q.longTimer, cfg_q.pow150, cfg_q.infinite, cfg_q.shorted};
   wire logic [31:0] clampWord = {6'h0, clamp200_q, 6'h0, clamp150_q};
   wire logic [31:0] rdMux = hitCtrl ? {31'h0, startEn_q} :
      hitOvp ? {22'h0, ovpLevel_q} :
      hitOpp ? {22'h0, oppLevel_q} :
      hitClamp ? clampWord :
      hitStatus ? statusWord :
      hitSettings ? settingsWord :
      hitBoost ? {22'h0, boostSample_q} : 32'h0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdData_q <= '0;
         rdErr_q <= 1'b0;
         rdValid_q <= 1'b0;
      end else if (clkEn) begin
         rdValid_q <= setupPhase;
         if (setupPhase) begin
            rdData_q <= pwrite ? 32'h0 : rdMux;
            rdErr_q <= !hitAny;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         startEn_q <= 1'b0;
         ovpLevel_q <= rpc_pkg::OVP_RESET;
         oppLevel_q <= rpc_pkg::OPP_RESET;
         clamp150_q <= rpc_pkg::CLAMP_RESET;
         clamp200_q <= rpc_pkg::CLAMP_RESET;
      end else if (clkEn && wrDo) begin
         if (hitCtrl) begin
            startEn_q <= pwdata[0];
         end
         if (hitOvp) begin
            ovpLevel_q <= pwdata[9:0];
         end
         if (hitOpp) begin
            oppLevel_q <= pwdata[9:0];
         end
         if (hitClamp) begin
            clamp150_q <= pwdata[9:0];
            clamp200_q <= pwdata[rpc_pkg::CLAMP_HI_POS +: 10];
         end
      end
   end

   assign pready = psel && penable && rdValid_q && clkEn;
   assign prdata = rdData_q;
   assign pslverr = pready && rdErr_q;

endmodule // rpc_protection

/* bench/rpc_pfc_model.sv */
// behavioural power factor stage seen through the shared boost-sense pin
`timescale 1ns/100ps
module rpc_pfc_model (
   input wire logic mclk,
   input wire logic boostPinOut,
   input wire logic boostPinOe,
   output logic pfcOn
);
   // the divider pulls the pin up when released
   wire logic pinLevel = boostPinOe ? boostPinOut : 1'b1;
   always_ff @(posedge mclk) begin
      pfcOn <= pinLevel;
   end
endmodule // rpc_pfc_model

/* bench/rpc_protection_monitor.sv */
// assertions of the resonant protection block
`timescale 1ns/100ps
module rpc_protection_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire rpc_pkg::rpc_sense_t senseRaw,
   input wire logic adcDone,
   input wire logic adcSelBoost,
   input wire logic [9:0] capSwing,
   input wire logic [9:0] capSwingLimited,
   input wire logic lowSideGate,
   input wire logic highSideGate,
   input wire logic boostPinOe,
   input wire logic hvStartupEn,
   input wire logic [1:0] burstSel
);
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("stray pready");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("stray pslverr");
   chk_ready_prompt: assert property (psel && !penable && clkEn |=> pready)
      else $error("late pready");
   chk_adc_alternate: assert property (adcDone && clkEn |=> adcSelBoost != $past(adcSelBoost))
      else $error("adc stuck");
   chk_ocp_cut: assert property (senseRaw.ocp [*7] |-> !lowSideGate && !highSideGate)
      else $error("ocp gate on");
   chk_capm_low: assert property (senseRaw.capmLs [*7] |-> !lowSideGate)
      else $error("capm low on");
   chk_capm_high: assert property (senseRaw.capmHs [*7] |-> !highSideGate)
      else $error("capm high on");
   chk_clamp_bound: assert property (clkEn |=> capSwingLimited <= $past(capSwing))
      else $error("clamp high");
   chk_stop_trip: assert property ($rose(boostPinOe) |=> !lowSideGate && !highSideGate)
      else $error("no stop");
   chk_gate_release: assert property (lowSideGate || highSideGate |-> !$past(boostPinOe))
      else $error("gate early");
   chk_hv_prot: assert property (boostPinOe |-> hvStartupEn)
      else $error("hv off");
   chk_set_held: assert property (!boostPinOe && !$past(boostPinOe) |-> $stable(burstSel))
      else $error("burst moved");
endmodule // rpc_protection_monitor

bind rpc_protection rpc_protection_monitor i_rpc_protection_monitor (.*);

/* bench/tb.sv */
// testbench of the resonant protection block
`timescale 1ns/100ps
module tb;
   logic mclk, rst, clkEn, psel, penable, pwrite, adcDone, cfgValid, cycleStart, gateLsReq, gateHsReq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic pready, pslverr, rerr, adcSelBoost, lowSideGate, highSideGate, pfcOn;
   logic boostPinOut, boostPinOe, settingsPinOut, settingsPinOe, hvStartupEn;
   logic [9:0] adcData, capSwing, capSwingLimited;
   logic [11:0] cfgSetRes, cfgBurstRes, cfgGateLsRes;
   logic [1:0] burstSel;
   rpc_pkg::rpc_sense_t senseRaw;
   int err_count, checks_done;
   // short counts keep the run small
   rpc_protection #(.OPP_SHORT_CYC(50), .OPP_LONG_CYC(200), .PG_SHORT_CYC(45),
      .PG_LONG_CYC(190), .RESTART_CYC(100)) i_rpc_protection (.*);
   rpc_pfc_model i_rpc_pfc_model (.*);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      chk("pready", {31'h0, pready}, 32'h1);
   endtask
   task rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rdat & m, e);
   endtask
   task st(input logic [31:0] e);
      rd("state", rpc_pkg::ADDR_STATUS, 32'h7, e);
   endtask
   task boot(input logic [11:0] s, input logic [11:0] b, input logic go);
      @(posedge mclk);
      rst <= 1'b1; cfgValid <= 1'b0; senseRaw <= '0; gateLsReq <= 1'b0; capSwing <= 10'h0;
      gateHsReq <= 1'b0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      cfgSetRes <= s; cfgBurstRes <= b; cfgGateLsRes <= 12'h123; cfgValid <= 1'b1;
      @(posedge mclk);
      cfgValid <= 1'b0;
      repeat (2) @(posedge mclk);
      if (go) apb(1'b1, rpc_pkg::ADDR_CTRL, 32'h1);
   endtask
   task cyc(input int n);
      repeat (n) begin
         @(posedge mclk); cycleStart <= 1'b1;
         @(posedge mclk); cycleStart <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask
   // two conversions refresh the output channel
   task adc(input logic [9:0] v);
      repeat (2) begin
         @(posedge mclk); adcData <= v; adcDone <= 1'b1;
         @(posedge mclk); adcDone <= 1'b0;
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_regs;
      boot(rpc_pkg::SET_CODES[1], rpc_pkg::BURST_CODES[0], 1'b0);
      chk("boostOe", {31'h0, boostPinOe}, 32'h0);
      rd("ctrl", rpc_pkg::ADDR_CTRL, '1, 32'h0);
      rd("ovp", rpc_pkg::ADDR_OVP, '1, 32'h3FF);
      rd("opp", rpc_pkg::ADDR_OPP, '1, 32'h3FF);
      rd("clamp", rpc_pkg::ADDR_CLAMP, '1, 32'h03FF03FF);
      rd("gateRes", rpc_pkg::ADDR_SETTINGS, 32'h000FFF00, 32'h00012300);
      apb(1'b1, 8'h1C, 32'hFFFFFFFF);
      rd("unmapped", 8'h1C, '1, 32'h0);
      chk("slverr", {31'h0, rerr}, 32'h1);
   endtask
   task t_decode;
      logic [2:0] b;
      for (int k = 0; k < 9; k++) begin
         boot(rpc_pkg::SET_CODES[k] + 12'h003, rpc_pkg::BURST_CODES[k % 4] + 12'h001, 1'b0);
         b = 3'(k - 1);
         if (k == 0) rd("set", rpc_pkg::ADDR_SETTINGS, 32'h6, 32'h2);
         else rd("set", rpc_pkg::ADDR_SETTINGS, 32'h1E, {27'h0, b[2], ~b[0], b[1], 2'h0});
         chk("burst", {30'h0, burstSel}, 32'(k % 4));
         st(32'h2);
      end
   endtask
   task t_short;
      boot(12'h050, rpc_pkg::BURST_CODES[0], 1'b1);
      st(32'h1);
   endtask
   task t_ovp;
      boot(rpc_pkg::SET_CODES[1], rpc_pkg::BURST_CODES[1], 1'b1);
      gateLsReq <= 1'b1;
      apb(1'b1, rpc_pkg::ADDR_OVP, 32'h100);
      adc(10'h200); cyc(4); adc(10'h010); cyc(1); adc(10'h200); cyc(4);
      st(32'h3);
      cyc(1);
      st(32'h5);
      chk("pfcOn", {31'h0, pfcOn}, 32'h0);
      chk("gate", {31'h0, lowSideGate}, 32'h0);
      chk("pgood", {30'h0, settingsPinOe, settingsPinOut}, 32'h2);
      repeat (300) @(posedge mclk);
      st(32'h5);
   endtask
   task t_ocp;
      boot(rpc_pkg::SET_CODES[1], rpc_pkg::BURST_CODES[2], 1'b1);
      gateLsReq <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("gateOn", {31'h0, lowSideGate}, 32'h1);
      senseRaw.capmLs <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("capmCut", {31'h0, lowSideGate}, 32'h0);
      st(32'h3);
      senseRaw.capmLs <= 1'b0; gateLsReq <= 1'b0;
      repeat (6) @(posedge mclk);
      gateHsReq <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("gateBack", {31'h0, highSideGate}, 32'h1);
      senseRaw.ocp <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("ocpCut", {31'h0, highSideGate}, 32'h0);
      cyc(4);
      st(32'h3);
      cyc(1);
      st(32'h5);
      chk("pfcOn", {31'h0, pfcOn}, 32'h0);
   endtask
   task t_otp;
      boot(rpc_pkg::SET_CODES[1], rpc_pkg::BURST_CODES[3], 1'b1);
      clkEn <= 1'b0;
      senseRaw.otp <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("frozen", {31'h0, boostPinOe}, 32'h0);
      clkEn <= 1'b1;
      repeat (8) @(posedge mclk);
      st(32'h5);
      chk("pfcOn", {31'h0, pfcOn}, 32'h0);
   endtask
   task t_opp;
      boot(rpc_pkg::SET_CODES[2], rpc_pkg::BURST_CODES[0], 1'b1);
      apb(1'b1, rpc_pkg::ADDR_OPP, 32'h080);
      apb(1'b1, rpc_pkg::ADDR_CLAMP, 32'h00F000C0);
      capSwing <= 10'h100;
      repeat (3) @(posedge mclk);
      chk("clamp", {22'h0, capSwingLimited}, 32'h0F0);
      repeat (37) @(posedge mclk);
      st(32'h3);
      repeat (20) @(posedge mclk);
      st(32'h4);
      chk("hvOn", {31'h0, hvStartupEn}, 32'h1);
      capSwing <= 10'h0;
      repeat (110) @(posedge mclk);
      st(32'h0);
   endtask
   task t_inf;
      boot(rpc_pkg::SET_CODES[0], rpc_pkg::BURST_CODES[0], 1'b1);
      apb(1'b1, rpc_pkg::ADDR_OPP, 32'h080);
      capSwing <= 10'h100;
      repeat (300) @(posedge mclk);
      st(32'h3);
   endtask
   initial begin
      #300000;
      err_count++;
      wrap_up;
   end
   initial begin
      rst = 1'b1; clkEn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
      pwdata = 32'h0;
      adcDone = 1'b0; adcData = 10'h0; cfgValid = 1'b0; cycleStart = 1'b0; gateLsReq = 1'b0;
      gateHsReq = 1'b0; capSwing = 10'h0; senseRaw = '0; cfgSetRes = 12'h0;
      cfgBurstRes = 12'h0; cfgGateLsRes = 12'h0; err_count = 0; checks_done = 0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      t_regs; t_decode; t_short; t_ovp; t_ocp; t_otp; t_opp; t_inf;
      wrap_up;
   end
endmodule // tb
